/* File: clock_source_interrupt_reg.sv */
`timescale 1ns/100ps
module clock_source_interrupt_reg
  import clock_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  input wire logic [NUM_SRC-1:0] sourceStable,
  input wire logic crystalStopped,
  output logic clockIrq
);
  // ==========================================================
  // register decode
  logic hitWrite;
  logic hitRead;
  logic [NUM_SRC-1:0] clearHit;
  logic stuckClearHit;
  logic [NUM_SRC-1:0] sourceStableD_r;
  logic [NUM_SRC-1:0] stableRise;
  logic [NUM_SRC-1:0] setHit;
  logic [NUM_SRC-1:0] enables_r;
  logic [NUM_SRC-1:0] flags;
  logic stuckFlag;
  logic [DATA_W-1:0] readValue;

  function automatic logic addrHit(input logic [ADDR_W-1:0] a);
    return a == CLOCK_EVENT_INTERRUPT_OFFS;
  endfunction

  assign hitWrite = regWrite && addrHit(regAddr);
  assign hitRead = regRead && addrHit(regAddr);
  // clear bits are write-only strobes; they never hold state
  assign clearHit = hitWrite ?
    regWdata[CLEAR_LSB +: NUM_SRC] : '0;
  assign stuckClearHit = hitWrite && regWdata[STUCK_CLEAR_POS];

  // ==========================================================
  // enables
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      enables_r <= ENABLES_RST;
    end else if (hitWrite) begin
      enables_r <= regWdata[ENABLE_LSB +: NUM_SRC];
    end
  end

  // ==========================================================
  // stable events: a rising stable level is one event, so a source
  // that stays stable does not refire after software clears it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sourceStableD_r <= FLAGS_RST;
    end else begin
      sourceStableD_r <= sourceStable;
    end
  end

  assign stableRise = sourceStable & ~sourceStableD_r;
  assign setHit = stableRise & enables_r;

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      stable_event_cell u_cell (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .setEvent(setHit[i]),
        .clearEvent(clearHit[i]),
        .flag_r(flags[i])
      );
    end
  endgenerate

  // stuck is a level from the monitor; held high it keeps re-setting
  stable_event_cell u_stuck (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .setEvent(crystalStopped),
    .clearEvent(stuckClearHit),
    .flag_r(stuckFlag)
  );

  // ==========================================================
  // read path; reserved and write-only bits read zero
  always_comb begin
    readValue = CLOCK_EVENT_INTERRUPT_RST;
    readValue[FLAG_LSB +: NUM_SRC] = flags;
    readValue[STUCK_FLAG_POS] = stuckFlag;
    readValue[ENABLE_LSB +: NUM_SRC] = enables_r;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdata <= CLOCK_EVENT_INTERRUPT_RST;
    end else if (hitRead) begin
      regRdata <= readValue;
    end else begin
      regRdata <= CLOCK_EVENT_INTERRUPT_RST;
    end
  end

  // ==========================================================
  // interrupt request; registered, so one cycle behind the flags
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clockIrq <= 1'b0;
    end else begin
      clockIrq <= (|flags) || stuckFlag;
    end
  end

  // ==========================================================
  // checks
  resetZero_a: assert property (@(posedge clk_sys)
    $rose(nrst) |-> flags == '0 && !stuckFlag && enables_r == '0)
    else $error("register not zero after reset");

  stuckSet_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) crystalStopped |=> stuckFlag)
    else $error("stuck flag not set");

  stuckClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) stuckClearHit && !crystalStopped |=> !stuckFlag)
    else $error("stuck flag not cleared");

  stableClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) hitWrite && regWdata[CLEAR_LSB+6] && !setHit[6]
    |=> !flags[6])
    else $error("loop3 flag not cleared");

  zeroNoClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) hitWrite && !regWdata[CLEAR_LSB+3] && flags[3]
    |=> flags[3])
    else $error("zero write cleared flag");

  enableStore_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) hitWrite |=> enables_r ==
    $past(regWdata[ENABLE_LSB +: NUM_SRC]))
    else $error("enables not stored");

  gatedSet_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) $rose(flags[2]) |-> $past(setHit[2]))
    else $error("flag set without enabled event");

  irqFollows_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) ((|flags) || stuckFlag) |=> clockIrq)
    else $error("irq missing");

  readBack_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) hitRead |=> regRdata[31:24] == 8'h00
    && regRdata[15] == 1'b0 && regRdata[23:16] == 8'h00)
    else $error("reserved bits not zero");

  // per-source checks so a failure names the oscillator; loop3 clear, fast crystal keep and fast rc gating use the generic checks above

  loop2Clear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && regWdata[CLEAR_LSB+5] && !setHit[5] |=> !flags[5])
    else $error("loop2 flag not cleared");

  mainLoopClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && regWdata[CLEAR_LSB+4] && !setHit[4] |=> !flags[4])
    else $error("main loop flag not cleared");

  fastCrystalClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && regWdata[CLEAR_LSB+3] && !setHit[3] |=> !flags[3])
    else $error("fast crystal flag not cleared");

  fastRcClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && regWdata[CLEAR_LSB+2] && !setHit[2] |=> !flags[2])
    else $error("fast rc flag not cleared");

  slowCrystalClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && regWdata[CLEAR_LSB+1] && !setHit[1] |=> !flags[1])
    else $error("slow crystal flag not cleared");

  slowRcClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && regWdata[CLEAR_LSB+0] && !setHit[0] |=> !flags[0])
    else $error("slow rc flag not cleared");

  loop3Keep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[CLEAR_LSB+6] && flags[6] |=> flags[6])
    else $error("zero write cleared loop3 flag");

  loop2Keep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[CLEAR_LSB+5] && flags[5] |=> flags[5])
    else $error("zero write cleared loop2 flag");

  mainLoopKeep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[CLEAR_LSB+4] && flags[4] |=> flags[4])
    else $error("zero write cleared main loop flag");

  fastRcKeep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[CLEAR_LSB+2] && flags[2] |=> flags[2])
    else $error("zero write cleared fast rc flag");

  slowCrystalKeep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[CLEAR_LSB+1] && flags[1] |=> flags[1])
    else $error("zero write cleared slow crystal flag");

  slowRcKeep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[CLEAR_LSB+0] && flags[0] |=> flags[0])
    else $error("zero write cleared slow rc flag");

  stuckKeep_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite && !regWdata[STUCK_CLEAR_POS] && stuckFlag |=> stuckFlag)
    else $error("zero write cleared stuck flag");

  loop3Enable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[6] == $past(regWdata[ENABLE_LSB+6]))
    else $error("loop3 enable not stored");

  loop2Enable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[5] == $past(regWdata[ENABLE_LSB+5]))
    else $error("loop2 enable not stored");

  mainLoopEnable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[4] == $past(regWdata[ENABLE_LSB+4]))
    else $error("main loop enable not stored");

  fastCrystalEnable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[3] == $past(regWdata[ENABLE_LSB+3]))
    else $error("fast crystal enable not stored");

  fastRcEnable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[2] == $past(regWdata[ENABLE_LSB+2]))
    else $error("fast rc enable not stored");

  slowCrystalEnable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[1] == $past(regWdata[ENABLE_LSB+1]))
    else $error("slow crystal enable not stored");

  slowRcEnable_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitWrite |=> enables_r[0] == $past(regWdata[ENABLE_LSB+0]))
    else $error("slow rc enable not stored");

  loop3Fires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[6] && enables_r[6] |=> flags[6])
    else $error("enabled loop3 event lost");

  loop2Fires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[5] && enables_r[5] |=> flags[5])
    else $error("enabled loop2 event lost");

  mainLoopFires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[4] && enables_r[4] |=> flags[4])
    else $error("enabled main loop event lost");

  fastCrystalFires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[3] && enables_r[3] |=> flags[3])
    else $error("enabled fast crystal event lost");

  fastRcFires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[2] && enables_r[2] |=> flags[2])
    else $error("enabled fast rc event lost");

  slowCrystalFires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[1] && enables_r[1] |=> flags[1])
    else $error("enabled slow crystal event lost");

  slowRcFires_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    stableRise[0] && enables_r[0] |=> flags[0])
    else $error("enabled slow rc event lost");

  loop3Gated_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    $rose(flags[6]) |-> $past(setHit[6]))
    else $error("loop3 flag set without enabled event");

  loop2Gated_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    $rose(flags[5]) |-> $past(setHit[5]))
    else $error("loop2 flag set without enabled event");

  mainLoopGated_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    $rose(flags[4]) |-> $past(setHit[4]))
    else $error("main loop flag set without enabled event");

  fastCrystalGated_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    $rose(flags[3]) |-> $past(setHit[3]))
    else $error("fast crystal flag set without enabled event");

  slowCrystalGated_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    $rose(flags[1]) |-> $past(setHit[1]))
    else $error("slow crystal flag set without enabled event");

  slowRcGated_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    $rose(flags[0]) |-> $past(setHit[0]))
    else $error("slow rc flag set without enabled event");

  irqDrop_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    !(|flags) && !stuckFlag |=> !clockIrq)
    else $error("irq held with no flag set");

  readStuck_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitRead |=> regRdata[STUCK_FLAG_POS] == $past(stuckFlag))
    else $error("stuck flag read wrong");

  readFlags_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitRead |=> regRdata[FLAG_LSB +: NUM_SRC] == $past(flags))
    else $error("stable flags read wrong");

  readEnables_a: assert property (@(posedge clk_sys)
    disable iff (!nrst)
    hitRead |=> regRdata[ENABLE_LSB +: NUM_SRC] == $past(enables_r))
    else $error("enables read wrong");

  stableEvent_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    setHit[4] ##[1:20] clearHit[4]);
  stuckEvent_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    crystalStopped ##[1:20] stuckClearHit);
  stuckHold_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    stuckFlag [*3]);
  irqDrop_c: cover property (@(posedge clk_sys) disable iff (!nrst)
    $fell(clockIrq));
endmodule

/* File: clock_irq_pkg.sv */
package clock_irq_pkg;
  // ==========================================================
  // Overview of operation
  // - interrupt register at offset 0x08, all bits zero after reset
  // - hardware sets stuck flag bit 7 when fast crystal clock stops
  // - writing one to bit 23 clears the stuck flag; zero leaves it
  // - writing one to bit 22 clears third loop stable flag
  // - writing one to bit 21 clears second loop stable flag
  // - writing one to bit 20 clears main loop stable flag
  // - writing one to bit 19 clears fast crystal stable flag
  // - writing one to bit 18 clears fast rc stable flag
  // - writing one to bit 17 clears slow crystal stable flag
  // - writing one to bit 16 clears slow rc stable flag
  // - bit 14 enables third loop stable interrupt
  // - bit 13 enables second loop stable interrupt
  // - bit 12 enables main loop stable interrupt
  // - bit 11 enables fast crystal stable interrupt
  // - bit 10 enables fast rc stable interrupt
  // - bit 9 enables slow crystal stable interrupt
  // - bit 8 enables slow rc stable interrupt
  // - stable flags 6..0 set only on stable event with enable high

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 7;
  localparam logic [ADDR_W-1:0] CLOCK_EVENT_INTERRUPT_OFFS = 8'h08;
  localparam logic [DATA_W-1:0] CLOCK_EVENT_INTERRUPT_RST = 32'h0000_0000;
  // field positions; source index 6..0 = loop3, loop2, main loop,
  // fast crystal, fast rc, slow crystal, slow rc
  localparam int FLAG_LSB = 0;
  localparam int STUCK_FLAG_POS = 7;
  localparam int ENABLE_LSB = 8;
  localparam int CLEAR_LSB = 16;
  localparam int STUCK_CLEAR_POS = 23;
  localparam logic [NUM_SRC-1:0] FLAGS_RST = 7'h00;
  localparam logic [NUM_SRC-1:0] ENABLES_RST = 7'h00;
endpackage

/* File: stable_event_cell.sv */
`timescale 1ns/100ps
// one sticky event flag with write-one-to-clear; set wins over clear
module stable_event_cell
  import clock_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic setEvent,
  input wire logic clearEvent,
  output logic flag_r
);
  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (clearEvent) begin
      flag_nxt = 1'b0;
    end
    if (setEvent) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  setWinsOverClear_a: assert property (@(posedge clk_sys)
    disable iff (!nrst) setEvent |=> flag_r)
    else $error("event lost against clear");
endmodule

/* File: clock_source_interrupt_reg_bench.sv */
`timescale 1ns/100ps
module clock_source_interrupt_reg_bench
  import clock_irq_pkg::*;
;
  // ==========================================================
  // stimulus and design
  localparam logic [ADDR_W-1:0] ADR = CLOCK_EVENT_INTERRUPT_OFFS;
  localparam logic [DATA_W-1:0] ONE = 32'h0000_0001;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic [NUM_SRC-1:0] sourceStable = '0;
  logic crystalStopped = 1'b0;
  logic clockIrq;
  logic [DATA_W-1:0] en;
  int numErrors = 0;
  int checkCount = 0;
  int cycles = 0;

  clock_source_interrupt_reg u_clock_source_interrupt_reg (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .sourceStable(sourceStable),
    .crystalStopped(crystalStopped), .clockIrq(clockIrq));

  always #12.5 clk_sys = ~clk_sys;

  // ==========================================================
  // bus tasks and checks
  task automatic check(input logic [DATA_W-1:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkIrq(input logic e);
    check({{(DATA_W-1){1'b0}}, clockIrq}, {{(DATA_W-1){1'b0}}, e});
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 check(regRdata, e);
  endtask

  task automatic reportAndStop;
    if (numErrors == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      numErrors++;
      reportAndStop();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(ADR, CLOCK_EVENT_INTERRUPT_RST);
    chkIrq(1'b0);
    wr(8'h0C, 32'h0000_7F00);
    rd(8'h0C, 32'h0000_0000);
    rd(ADR, 32'h0000_0000);
    // one enable at a time, every source rising, so only one may flag
    for (int i = 0; i < NUM_SRC; i++) begin
      en = ONE << (ENABLE_LSB + i);
      @(posedge clk_sys);
      sourceStable <= '0;
      wr(ADR, en);
      rd(ADR, en);
      @(posedge clk_sys);
      sourceStable <= 7'h7F;
      repeat (3) @(posedge clk_sys);
      rd(ADR, en | (ONE << i));
      chkIrq(1'b1);
      wr(ADR, en);
      rd(ADR, en | (ONE << i));
      wr(ADR, en | (ONE << (CLEAR_LSB + i)));
      rd(ADR, en);
      chkIrq(1'b0);
    end
    wr(ADR, 32'h0000_0000);
    @(posedge clk_sys);
    crystalStopped <= 1'b1;
    @(posedge clk_sys);
    crystalStopped <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(ADR, ONE << STUCK_FLAG_POS);
    chkIrq(1'b1);
    wr(ADR, 32'h0000_0000);
    rd(ADR, ONE << STUCK_FLAG_POS);
    wr(ADR, ONE << STUCK_CLEAR_POS);
    rd(ADR, 32'h0000_0000);
    chkIrq(1'b0);
    reportAndStop();
  end
endmodule
